// File: hw/irq_ack_pkg.sv
// constants, types and state codes for the interrupt acknowledge and arbitration block
package irq_ack_pkg;

    localparam int          NUM_MOD        = 3;
    localparam int          NUM_SRC        = NUM_MOD + 1;
    localparam int          SIM_INDEX      = 0;
    localparam int          ARB_BITS       = 4;
    localparam logic [3:0]  ARB_RESET_SIM  = 4'hF;
    localparam logic [3:0]  ARB_RESET_MOD  = 4'h0;
    localparam logic [1:0]  ARB_TOP_BIT    = 2'h3;

    localparam logic [2:0]  FC_CPU_SPACE   = 3'h7;
    localparam logic [2:0]  FC_IDLE        = 3'h0;
    localparam logic [19:0] ACK_ADDR_HIGH  = 20'hFFFFF;
    localparam logic        ACK_ADDR_LSB   = 1'h1;
    localparam logic [2:0]  LEVEL_NMI      = 3'h7;

    localparam int          MASK_LSB       = 5;
    localparam int          MASK_MSB       = 7;
    localparam int          PAGE_LSB       = 0;
    localparam int          PAGE_MSB       = 3;
    localparam logic [15:0] CCR_RESET      = 16'h00E0;

    localparam logic [7:0]  SPURIOUS_VEC   = 8'h18;
    localparam logic [7:0]  AUTOVEC_BASE   = 8'h18;
    localparam int          VEC_ADDR_SHIFT = 1;

    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          EXT_TIMEOUT_NS = 640;
    localparam int          EXT_TIMEOUT_CYC = EXT_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_STACK   = 9'h002,
        ST_ACK     = 9'h004,
        ST_ARB     = 9'h008,
        ST_RESOLVE = 9'h010,
        ST_EXT     = 9'h020,
        ST_FAULT   = 9'h040,
        ST_VECTOR  = 9'h080,
        ST_FETCH   = 9'h100
    } ack_state_t;

endpackage

// File: hw/arb_contender.sv
// one contender of the serial arbitration bus
`timescale 1ns/1ps
module arb_contender (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       join_req,
    input  wire logic [3:0] field,
    input  wire logic [1:0] bit_sel,
    input  wire logic       step,
    input  wire logic       wired_bit,
    output logic            drive,
    output logic            active
);

    logic active_reg;
    logic active_next;

    always_comb
    begin
        active_next = active_reg;
        if (start)
        begin
            active_next = join_req;
        end
        else if (step && active_reg && wired_bit && !field[bit_sel])
        begin
            active_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            active_reg <= 1'b0;
        else
            active_reg <= active_next;
    end

    // wired-or: a one on the bus beats a zero, so the larger field survives
    assign drive  = active_reg & field[bit_sel];
    assign active = active_reg;

endmodule // arb_contender

// File: hw/interrupt_ack_arbitration.sv
// interrupt acknowledge sequencer with serial same-level arbitration
`timescale 1ns/1ps
module interrupt_ack_arbitration (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic [7:1]                        ext_irq_n,
    input  wire logic [irq_ack_pkg::NUM_MOD-1:0]   int_req,
    input  wire logic [irq_ack_pkg::NUM_MOD-1:0][2:0] int_level,
    input  wire logic [irq_ack_pkg::NUM_MOD-1:0][7:0] int_vector,
    input  wire logic                              tick_req,
    input  wire logic [2:0]                        tick_level,
    input  wire logic [7:0]                        tick_vector,
    input  wire logic [irq_ack_pkg::NUM_SRC-1:0]   arb_we,
    input  wire logic [3:0]                        arb_wdata,
    input  wire logic                              ccr_we,
    input  wire logic [15:0]                       ccr_wdata,
    input  wire logic                              insn_boundary,
    input  wire logic                              stack_done,
    input  wire logic                              ext_word_ack_n,
    input  wire logic [7:0]                        ext_vector,
    input  wire logic                              cs_enable,
    input  wire logic [2:0]                        cs_level,
    input  wire logic                              cs_autovector,
    input  wire logic                              fetch_done,
    input  wire logic [15:0]                       fetch_data,
    output logic [2:0]                             function_code_lines,
    output logic [23:0]                            ack_addr,
    output logic                                   ack_active,
    output logic                                   ext_ack_cycle,
    output logic                                   cs_select_n,
    output logic                                   bus_fault,
    output logic                                   stack_req,
    output logic                                   fetch_req,
    output logic [15:0]                            fetch_addr,
    output logic [15:0]                            pc,
    output logic [15:0]                            condition_code_reg,
    output logic [irq_ack_pkg::NUM_MOD-1:0]        src_ack,
    output logic                                   tick_ack,
    output logic                                   spurious_taken,
    output logic                                   autovector_taken,
    output logic [irq_ack_pkg::NUM_SRC-1:0][3:0]   arbitration_priority_field
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and request qualification

    logic [7:1] irq_s1_reg, irq_s1_next, irq_s2_reg, irq_s2_next, irq_s3_reg, irq_s3_next;
    logic       ack_s1_reg, ack_s1_next, ack_s2_reg, ack_s2_next;
    logic [7:0] vec_s1_reg, vec_s1_next, vec_s2_reg, vec_s2_next;
    logic [7:0] ext_valid;

    always_comb
    begin
        irq_s1_next = ext_irq_n;
        irq_s2_next = irq_s1_reg;
        irq_s3_next = irq_s2_reg;
        ack_s1_next = ext_word_ack_n;
        ack_s2_next = ack_s1_reg;
        vec_s1_next = ext_vector;
        vec_s2_next = vec_s1_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_s1_reg <= 7'h7F;
            irq_s2_reg <= 7'h7F;
            irq_s3_reg <= 7'h7F;
            ack_s1_reg <= 1'h1;
            ack_s2_reg <= 1'h1;
            vec_s1_reg <= 8'h00;
            vec_s2_reg <= 8'h00;
        end
        else
        begin
            irq_s1_reg <= irq_s1_next;
            irq_s2_reg <= irq_s2_next;
            irq_s3_reg <= irq_s3_next;
            ack_s1_reg <= ack_s1_next;
            ack_s2_reg <= ack_s2_next;
            vec_s1_reg <= vec_s1_next;
            vec_s2_reg <= vec_s2_next;
        end
    end

    // glitches shorter than two samples never count as a request
    assign ext_valid = {~irq_s2_reg & ~irq_s3_reg, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // arbitration fields

    logic [irq_ack_pkg::NUM_SRC-1:0][3:0] arb_reg, arb_next;

    always_comb
    begin
        arb_next = arb_reg;
        for (int i = 0; i < irq_ack_pkg::NUM_SRC; i++)
            if (arb_we[i])
                arb_next[i] = arb_wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < irq_ack_pkg::NUM_SRC; i++)
                arb_reg[i] <= (i == irq_ack_pkg::SIM_INDEX) ? irq_ack_pkg::ARB_RESET_SIM
                                                             : irq_ack_pkg::ARB_RESET_MOD;
        end
        else
            arb_reg <= arb_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending level and contention

    irq_ack_pkg::ack_state_t state_reg, state_next;
    logic [2:0]  level_reg, level_next, hp_level, mask;
    logic [1:0]  bit_reg, bit_next;
    logic        pending, tick_here, arb_start, arb_step, wired_bit, any_winner, sim_wins;
    logic [irq_ack_pkg::NUM_SRC-1:0] join_w, drive_w, active_w, winners_w;
    logic [7:0]  mod_vec;

    assign mask = condition_code_reg[irq_ack_pkg::MASK_MSB:irq_ack_pkg::MASK_LSB];

    always_comb
    begin
        hp_level = 3'h0;
        for (int l = 1; l < 8; l++)
        begin
            if (ext_valid[l] || (tick_req && tick_level == 3'(l)))
                hp_level = 3'(l);
            for (int m = 0; m < irq_ack_pkg::NUM_MOD; m++)
                if (int_req[m] && int_level[m] == 3'(l))
                    hp_level = 3'(l);
        end
    end

    assign pending = (hp_level != 3'h0) &&
                     ((hp_level > mask) || (hp_level == irq_ack_pkg::LEVEL_NMI));

    // the integration module stands for tick and every external line
    assign tick_here = tick_req && (tick_level == level_reg);
    always_comb
    begin
        join_w[irq_ack_pkg::SIM_INDEX] = ext_valid[level_reg] || tick_here;
        for (int m = 0; m < irq_ack_pkg::NUM_MOD; m++)
            join_w[m + 1] = int_req[m] && (int_level[m] == level_reg);
    end

    assign arb_start = (state_reg == irq_ack_pkg::ST_ACK);
    assign arb_step  = (state_reg == irq_ack_pkg::ST_ARB);
    assign wired_bit = |drive_w;

    for (genvar i = 0; i < irq_ack_pkg::NUM_SRC; i++)
    begin : g_contend
        arb_contender u_contender (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .start     (arb_start),
            .join_req  (join_w[i]),
            .field     (arb_reg[i]),
            .bit_sel   (bit_reg),
            .step      (arb_step),
            .wired_bit (wired_bit),
            .drive     (drive_w[i]),
            .active    (active_w[i])
        );
        // a zero field never drives, so it cannot win
        assign winners_w[i] = active_w[i] & (|arb_reg[i]);
    end

    assign any_winner = |winners_w;
    assign sim_wins   = winners_w[irq_ack_pkg::SIM_INDEX];

    always_comb
    begin
        mod_vec = 8'h00;
        for (int m = 0; m < irq_ack_pkg::NUM_MOD; m++)
            if (winners_w[m + 1])
                mod_vec = int_vector[m];
    end

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge sequencer

    logic [6:0]  tmo_reg, tmo_next;
    logic [15:0] ccr_reg, ccr_next, pc_reg, pc_next, faddr_reg, faddr_next;
    logic [2:0]  fc_reg, fc_next;
    logic [23:0] addr_reg, addr_next;
    logic [7:0]  vector_reg, vector_next;
    logic [irq_ack_pkg::NUM_MOD-1:0] src_ack_reg, src_ack_next;
    logic ack_reg, ack_next, ext_reg, ext_next, csn_reg, csn_next, fault_reg, fault_next;
    logic stack_reg, stack_next, fetch_reg, fetch_next, tack_reg, tack_next;
    logic spur_reg, spur_next, autovector_request_reg, autovector_request_next, cs_hit;

    assign cs_hit = cs_enable && (cs_level == level_reg);

    always_comb
    begin
        state_next  = state_reg;
        level_next  = level_reg;
        bit_next    = bit_reg;
        tmo_next    = tmo_reg;
        ccr_next    = ccr_we ? ccr_wdata : ccr_reg;
        pc_next     = pc_reg;
        faddr_next  = faddr_reg;
        fc_next     = fc_reg;
        addr_next   = addr_reg;
        vector_next = vector_reg;
        ack_next    = ack_reg;
        ext_next    = ext_reg;
        csn_next    = csn_reg;
        stack_next  = stack_reg;
        fetch_next  = fetch_reg;
        src_ack_next = '0;
        fault_next  = 1'b0;
        tack_next   = 1'b0;
        spur_next   = 1'b0;
        autovector_request_next   = 1'b0;
        case (state_reg)
            irq_ack_pkg::ST_IDLE:
                if (pending && insn_boundary)
                begin
                    level_next = hp_level;
                    stack_next = 1'b1;
                    state_next = irq_ack_pkg::ST_STACK;
                end
            irq_ack_pkg::ST_STACK:
                if (stack_done)
                begin
                    stack_next = 1'b0;
                    ccr_next[irq_ack_pkg::PAGE_MSB:irq_ack_pkg::PAGE_LSB] = 4'h0;
                    state_next = irq_ack_pkg::ST_ACK;
                end
            irq_ack_pkg::ST_ACK:
            begin
                fc_next    = irq_ack_pkg::FC_CPU_SPACE;
                addr_next  = {irq_ack_pkg::ACK_ADDR_HIGH, level_reg,
                              irq_ack_pkg::ACK_ADDR_LSB};
                ack_next   = 1'b1;
                ccr_next[irq_ack_pkg::MASK_MSB:irq_ack_pkg::MASK_LSB] = level_reg;
                bit_next   = irq_ack_pkg::ARB_TOP_BIT;
                state_next = irq_ack_pkg::ST_ARB;
            end
            irq_ack_pkg::ST_ARB:
            begin
                bit_next = bit_reg - 2'h1;
                if (bit_reg == 2'h0)
                    state_next = irq_ack_pkg::ST_RESOLVE;
            end
            irq_ack_pkg::ST_RESOLVE:
                if (!any_winner)
                    state_next = irq_ack_pkg::ST_FAULT;
                else if (sim_wins && tick_here)
                begin
                    vector_next = tick_vector;
                    tack_next   = 1'b1;
                    state_next  = irq_ack_pkg::ST_VECTOR;
                end
                else if (sim_wins)
                begin
                    ext_next   = 1'b1;
                    csn_next   = !cs_hit;
                    tmo_next   = 7'h00;
                    state_next = irq_ack_pkg::ST_EXT;
                end
                else
                begin
                    vector_next  = mod_vec;
                    src_ack_next = winners_w[irq_ack_pkg::NUM_SRC-1:1];
                    state_next   = irq_ack_pkg::ST_VECTOR;
                end
            irq_ack_pkg::ST_EXT:
                if (!csn_reg && cs_autovector)
                begin
                    vector_next = irq_ack_pkg::AUTOVEC_BASE + {5'h00, level_reg};
                    autovector_request_next   = 1'b1;
                    state_next  = irq_ack_pkg::ST_VECTOR;
                end
                else if (!ack_s2_reg)
                begin
                    vector_next = vec_s2_reg;
                    state_next  = irq_ack_pkg::ST_VECTOR;
                end
                else if (tmo_reg == 7'(irq_ack_pkg::EXT_TIMEOUT_CYC - 1))
                    state_next = irq_ack_pkg::ST_FAULT;
                else
                    tmo_next = tmo_reg + 7'h01;
            irq_ack_pkg::ST_FAULT:
            begin
                fault_next  = 1'b1;
                spur_next   = 1'b1;
                vector_next = irq_ack_pkg::SPURIOUS_VEC;
                state_next  = irq_ack_pkg::ST_VECTOR;
            end
            irq_ack_pkg::ST_VECTOR:
            begin
                fc_next    = irq_ack_pkg::FC_IDLE;
                addr_next  = 24'h000000;
                ack_next   = 1'b0;
                ext_next   = 1'b0;
                csn_next   = 1'b1;
                fetch_next = 1'b1;
                faddr_next = 16'({8'h00, vector_reg} << irq_ack_pkg::VEC_ADDR_SHIFT);
                state_next = irq_ack_pkg::ST_FETCH;
            end
            irq_ack_pkg::ST_FETCH:
                if (fetch_done)
                begin
                    fetch_next = 1'b0;
                    pc_next    = fetch_data;
                    state_next = irq_ack_pkg::ST_IDLE;
                end
            default:
                state_next = irq_ack_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= irq_ack_pkg::ST_IDLE;
            level_reg <= 3'h0;  bit_reg <= 2'h0;  tmo_reg <= 7'h00;
            ccr_reg <= irq_ack_pkg::CCR_RESET;  pc_reg <= 16'h0000;  faddr_reg <= 16'h0000;
            fc_reg <= irq_ack_pkg::FC_IDLE;  addr_reg <= 24'h000000;  vector_reg <= 8'h00;
            ack_reg <= 1'b0;  ext_reg <= 1'b0;  csn_reg <= 1'b1;  fault_reg <= 1'b0;
            stack_reg <= 1'b0;  fetch_reg <= 1'b0;  src_ack_reg <= '0;
            tack_reg <= 1'b0;  spur_reg <= 1'b0;  autovector_request_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            level_reg <= level_next;  bit_reg <= bit_next;  tmo_reg <= tmo_next;
            ccr_reg <= ccr_next;  pc_reg <= pc_next;  faddr_reg <= faddr_next;
            fc_reg <= fc_next;  addr_reg <= addr_next;  vector_reg <= vector_next;
            ack_reg <= ack_next;  ext_reg <= ext_next;  csn_reg <= csn_next;
            fault_reg <= fault_next;  stack_reg <= stack_next;  fetch_reg <= fetch_next;
            src_ack_reg <= src_ack_next;  tack_reg <= tack_next;
            spur_reg <= spur_next;  autovector_request_reg <= autovector_request_next;
        end
    end

    assign function_code_lines        = fc_reg;
    assign ack_addr                   = addr_reg;
    assign ack_active                 = ack_reg;
    assign ext_ack_cycle              = ext_reg;
    assign cs_select_n                = csn_reg;
    assign bus_fault                  = fault_reg;
    assign stack_req                  = stack_reg;
    assign fetch_req                  = fetch_reg;
    assign fetch_addr                 = faddr_reg;
    assign pc                         = pc_reg;
    assign condition_code_reg         = ccr_reg;
    assign src_ack                    = src_ack_reg;
    assign tick_ack                   = tack_reg;
    assign spurious_taken             = spur_reg;
    assign autovector_taken           = autovector_request_reg;
    assign arbitration_priority_field = arb_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions and covers

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_start_gate: assert property ($rose(stack_reg) |-> $past(pending) && $past(insn_boundary))
        else $error("acknowledge started without pending request at boundary");
    a_page_clear: assert property (state_reg == irq_ack_pkg::ST_STACK && stack_done && !ccr_we
        |=> ccr_reg[3:0] == 4'h0 ##1 fc_reg == irq_ack_pkg::FC_CPU_SPACE)
        else $error("page extension not cleared before acknowledge");
    a_fc_cpu_space: assert property (ack_reg |-> fc_reg == irq_ack_pkg::FC_CPU_SPACE)
        else $error("function code not cpu space during acknowledge");
    a_ack_addr_form: assert property (ack_reg |-> addr_reg[23:4] == 20'hFFFFF &&
        addr_reg[0] && addr_reg[3:1] == level_reg)
        else $error("acknowledge address malformed");
    a_mask_latched: assert property ($rose(ack_reg) && !$past(ccr_we) |-> mask == level_reg)
        else $error("mask not loaded with acknowledged level");
    a_arb_length: assert property (state_reg == irq_ack_pkg::ST_ACK |=>
        state_reg == irq_ack_pkg::ST_ARB [*4] ##1 state_reg == irq_ack_pkg::ST_RESOLVE)
        else $error("contention did not take four bit times");
    a_fault_spurious: assert property (state_reg == irq_ack_pkg::ST_RESOLVE && !any_winner
        |=> ##1 fault_reg && spur_reg && vector_reg == irq_ack_pkg::SPURIOUS_VEC)
        else $error("no contender did not end in spurious fault");
    a_ext_only_sim: assert property ($rose(ext_reg) |-> $past(sim_wins) && !$past(tick_here))
        else $error("external acknowledge without integration module win");
    a_tick_first: assert property (state_reg == irq_ack_pkg::ST_RESOLVE && sim_wins && tick_here
        |=> tack_reg && !ext_reg && vector_reg == $past(tick_vector))
        else $error("periodic tick not served before external");
    a_reset_fields: assert property ($past(rst) |->
        arb_reg[0] == 4'hF && arb_reg[1] == 4'h0)
        else $error("arbitration fields wrong after reset");
    a_autovector: assert property (autovector_request_reg |-> vector_reg == 8'h18 + {5'h00, level_reg})
        else $error("autovector does not match level");
    a_vector_fetch: assert property (state_reg == irq_ack_pkg::ST_VECTOR |=>
        fetch_reg && faddr_reg == {7'h00, vector_reg, 1'b0} && !ack_reg)
        else $error("vector address not issued");
    a_nmi_unmasked: assert property (state_reg == irq_ack_pkg::ST_IDLE && insn_boundary &&
        hp_level == 3'h7 |=> stack_reg)
        else $error("level seven request was masked");

    c_module_win: cover property (|src_ack_reg);
    c_ext_vector: cover property (state_reg == irq_ack_pkg::ST_EXT && !ack_s2_reg);
    c_ext_timeout: cover property (state_reg == irq_ack_pkg::ST_EXT ##1
        state_reg == irq_ack_pkg::ST_FAULT);
    c_autovector: cover property (autovector_request_reg);

endmodule // interrupt_ack_arbitration

// File: tb/ext_periph.sv
// far-side peripheral model answering external acknowledge cycles
`timescale 1ns/1ps
module ext_periph (
    input  wire logic       sys_clk,
    input  wire logic       ack_cycle,
    input  wire logic       mute,
    input  wire logic [7:0] vec,
    output logic            word_ack_n,
    output logic [7:0]      vec_out
);
    int cnt = 0;
    always @(posedge sys_clk)
    begin
        cnt <= ack_cycle ? cnt + 1 : 0;
        // vector settles well before the ack; a released bus shows the inverse
        vec_out <= ack_cycle ? vec : ~vec;
        word_ack_n <= !(ack_cycle && !mute && cnt >= 3);
    end
endmodule // ext_periph

// File: tb/tb.sv
// self-checking bench for the interrupt acknowledge sequencer
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0, rst = 1'b1, tick_req = 1'b0, ccr_we = 1'b0, mute = 1'b0;
    logic stack_done = 1'b0, fetch_done = 1'b0, insn_boundary = 1'b0;
    logic cs_enable = 1'b0, cs_autovector = 1'b0, pa = 1'b0, pf = 1'b0;
    logic [7:1] ext_irq_n = 7'h7F;
    logic [2:0] int_req = 3'h0, tick_level = 3'h6, cs_level = 3'h6;
    logic [2:0][2:0] int_level = '0;
    logic [2:0][7:0] int_vector = '0;
    logic [7:0] tick_vector = 8'h00, pv = 8'h00, ext_vector;
    logic [3:0] arb_we = 4'h0, arb_wdata = 4'h0;
    logic [15:0] ccr_wdata = 16'h000F, fetch_data = 16'h0000;
    logic [2:0] function_code_lines, src_ack;
    logic [23:0] ack_addr;
    logic ext_word_ack_n, ack_active, ext_ack_cycle, cs_select_n, bus_fault, stack_req;
    logic fetch_req, tick_ack, spurious_taken, autovector_taken;
    logic [15:0] fetch_addr, pc, condition_code_reg;
    logic [3:0][3:0] arbitration_priority_field;
    logic [31:0] rnd = 32'hD27E4E7A;
    logic [19:0] q[$];
    logic [19:0] e;
    logic [8:0] fl = 9'h000;
    int fail_count = 0, num_checks = 0;
    ext_periph peer (
        .sys_clk    (sys_clk),
        .ack_cycle  (ext_ack_cycle),
        .mute       (mute),
        .vec        (pv),
        .word_ack_n (ext_word_ack_n),
        .vec_out    (ext_vector)
    );
    interrupt_ack_arbitration uut (.*);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        stack_done <= stack_req && !stack_done;
        fetch_done <= fetch_req && !fetch_done;
    end
    ////////////////////////////////////////
    function automatic logic [7:0] nxt();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd[7:0];
    endfunction
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // note expectation, write ccr_wdata to the ccr, hold off the boundary, wait for the handler fetch
    task automatic run(input logic [2:0] lvl, input logic [8:0] fx, input logic [7:0] vec);
        int i;
        q.push_back({lvl, fx, vec});
        @(posedge sys_clk);
        ccr_we <= 1'b1;
        fetch_data <= {nxt(), nxt()};
        @(posedge sys_clk);
        ccr_we <= 1'b0;
        repeat (6)
        begin
            @(negedge sys_clk);
            chk("early", stack_req, 1'b0);
        end
        @(posedge sys_clk);
        insn_boundary <= 1'b1;
        for (i = 0; i < 300 && !fetch_done; i++)
            @(posedge sys_clk);
        if (i == 300)
        begin
            fail_count++;
            end_sim();
        end
        int_req <= 3'h0;
        tick_req <= 1'b0;
        ext_irq_n <= 7'h7F;
        insn_boundary <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("pc", pc, fetch_data);
        @(posedge sys_clk);
    endtask
    // pulses and levels seen during one acknowledge, cleared when it starts
    always @(negedge sys_clk)
    begin
        fl = fl | {src_ack, tick_ack, spurious_taken, bus_fault, autovector_taken,
                   ext_ack_cycle, !cs_select_n};
        if (ack_active && !pa)
        begin
            e = q[0];
            fl = 9'h000;
            chk("fc", function_code_lines, irq_ack_pkg::FC_CPU_SPACE);
            chk("addr", ack_addr, {irq_ack_pkg::ACK_ADDR_HIGH, e[19:17], 1'b1});
            chk("mask", condition_code_reg[7:5], e[19:17]);
            chk("page", condition_code_reg[3:0], 4'h0);
        end
        if (fetch_req && !pf)
        begin
            e = q.pop_front();
            chk("vector", fetch_addr, {7'h00, e[7:0], 1'b0});
            chk("flags", fl, e[16:8]);
        end
        pa <= ack_active;
        pf <= fetch_req;
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk("fields", arbitration_priority_field, 16'h000F);
        @(posedge sys_clk);
        arb_we <= 4'h2;
        arb_wdata <= 4'h5;
        @(posedge sys_clk);
        arb_we <= 4'h4;
        arb_wdata <= 4'h9;
        int_vector <= {nxt(), nxt(), nxt()};
        int_level <= {3'h2, 3'h3, 3'h3};
        int_req <= 3'h3;
        @(posedge sys_clk);
        arb_we <= 4'h0;
        run(3'h3, 9'h080, int_vector[1]);
        int_req <= 3'h4;
        run(3'h2, 9'h018, irq_ack_pkg::SPURIOUS_VEC);
        // mask set to seven: only the unmaskable level may start
        ccr_wdata <= 16'h00EF;
        int_level <= {3'h2, 3'h3, 3'h7};
        int_req <= 3'h1;
        run(3'h7, 9'h040, int_vector[0]);
        ccr_wdata <= 16'h000F;
        tick_vector <= nxt();
        pv <= nxt();
        tick_req <= 1'b1;
        ext_irq_n <= 7'h5F;
        @(posedge sys_clk);
        run(3'h6, 9'h020, tick_vector);
        ext_irq_n <= 7'h5F;
        run(3'h6, 9'h002, pv);
        mute <= 1'b1;
        ext_irq_n <= 7'h5F;
        run(3'h6, 9'h01A, irq_ack_pkg::SPURIOUS_VEC);
        cs_enable <= 1'b1;
        cs_autovector <= 1'b1;
        ext_irq_n <= 7'h5F;
        run(3'h6, 9'h007, irq_ack_pkg::AUTOVEC_BASE + 8'h06);
        end_sim();
    end
endmodule // tb
